/* qsb_pkg.sv */
`default_nettype none
package qsb_pkg;
  // Channel and storage geometry
  localparam int NUM_CHAN    = 4;
  localparam int CHAN_W      = 2;
  localparam int WORD_W      = 32;
  localparam int ENTRY_W     = 72;
  localparam int ENTRY_DEPTH = 512;
  localparam int ADDR_W      = 9;
  localparam int COUNT_W     = 10;
  localparam int BUDGET_W    = 10;
  // One credit is 16 bytes, which is two 64-bit entries
  localparam int CREDIT_BYTES     = 16;
  localparam int ENTRY_BYTES      = 8;
  localparam int WORDS_PER_CREDIT = CREDIT_BYTES / ENTRY_BYTES;
  // Burst and threshold defaults, in credits and entries
  localparam int STARVE_BURST_DEFAULT = 8;
  localparam int HUNGRY_BURST_DEFAULT = 4;
  localparam int AE_THRESH_DEFAULT    = 255;
  // Returned flow-control status codes
  localparam logic [1:0] STATUS_STARVING = 2'h0;
  localparam logic [1:0] STATUS_HUNGRY   = 2'h1;
  // Modulo helpers and the zero data word
  localparam logic [2:0] MOD_NONE = 3'h0;
  localparam logic [2:0] MOD_STEP = 3'h1;
  localparam logic [WORD_W-1:0] WORD_ZERO = 32'h0;

  // One word from a receive core
  typedef struct packed {
    logic [WORD_W-1:0] data;
    logic              sop;
    logic              eop;
    logic              err;
    logic [1:0]        remainder_bytes;
  } qsb_rx_word_type;

  // One stored entry, 72 bits, end flag in three copies at the top
  typedef struct packed {
    logic [2:0]        eop;
    logic              sop;
    logic              err;
    logic [2:0]        modulo;
    logic [WORD_W-1:0] first;
    logic [WORD_W-1:0] second;
  } qsb_entry_type;

  typedef enum logic {ARB_IDLE, ARB_BURST} qsb_arb_state_type;
endpackage : qsb_pkg
`default_nettype wire

/* qsb_mem.sv */
`timescale 1ns/1ns
`default_nettype none
module qsb_mem
#(
  parameter int WIDTH  = 72,
  parameter int DEPTH  = 512,
  parameter int ADDR_W = 9
)
(
  // Clock
  input  wire logic              clk_i,
  // Write port
  input  wire logic              write_i,
  input  wire logic [ADDR_W-1:0] write_addr_i,
  input  wire logic [WIDTH-1:0]  write_data_i,
  // Read port
  input  wire logic [ADDR_W-1:0] read_addr_i,
  output logic      [WIDTH-1:0]  read_data_o
);
  logic [WIDTH-1:0] mem [DEPTH];

  ////////////////////////////////////////////////////////////////////////////
  // Storage array
  always_ff @(posedge clk_i)
  begin
    if (write_i)
      mem[write_addr_i] <= write_data_i;
  end

  // Write-first read so the head word is current the cycle after a write
  always_ff @(posedge clk_i)
  begin
    if (write_i && (write_addr_i == read_addr_i))
      read_data_o <= write_data_i;
    else
      read_data_o <= mem[read_addr_i];
  end
endmodule : qsb_mem
`default_nettype wire

/* qsb_bridge.sv */
`timescale 1ns/1ns
`default_nettype none
module qsb_bridge
#(
  parameter int STARVE_BURST = qsb_pkg::STARVE_BURST_DEFAULT,
  parameter int HUNGRY_BURST = qsb_pkg::HUNGRY_BURST_DEFAULT,
  parameter int AE_THRESH    = qsb_pkg::AE_THRESH_DEFAULT
)
(
  // Clock and reset
  input  wire logic                                 clk_i,
  input  wire logic                                 reset_i,
  // Receive cores
  input  wire qsb_pkg::qsb_rx_word_type [3:0]       rx_word_i,
  input  wire logic [qsb_pkg::NUM_CHAN-1:0]         receive_side_ready_i,
  output logic      [qsb_pkg::NUM_CHAN-1:0]         rx_read_enable_o,
  // Source core
  input  wire logic [qsb_pkg::NUM_CHAN-1:0][1:0]    channel_status_i,
  input  wire logic                                 source_fifo_full_i,
  output logic                                      source_fifo_write_o,
  output logic      [qsb_pkg::CHAN_W-1:0]           source_fifo_channel_o,
  output logic      [2*qsb_pkg::WORD_W-1:0]         source_fifo_data_o,
  output logic                                      source_fifo_start_flag_o,
  output logic                                      source_fifo_end_flag_o,
  output logic                                      source_fifo_error_flag_o,
  output logic      [2:0]                           source_fifo_byte_modulo_o,
  // Storage status
  output logic      [qsb_pkg::NUM_CHAN-1:0]         storage_full_o,
  output logic      [qsb_pkg::NUM_CHAN-1:0]         storage_almost_empty_o,
  output logic      [qsb_pkg::NUM_CHAN-1:0]         single_packet_flag_o,
  output logic      [qsb_pkg::NUM_CHAN-1:0]         packet_present_flag_o
);
  import qsb_pkg::*;
  // Checks sample on the rising edge and rest while reset is high
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  localparam logic [BUDGET_W-1:0] STARVE_WORDS =
    BUDGET_W'(STARVE_BURST * WORDS_PER_CREDIT);
  localparam logic [BUDGET_W-1:0] HUNGRY_WORDS =
    BUDGET_W'(HUNGRY_BURST * WORDS_PER_CREDIT);
  localparam logic [COUNT_W-1:0] FULL_COUNT = COUNT_W'(ENTRY_DEPTH);
  localparam logic [COUNT_W-1:0] AE_COUNT   = COUNT_W'(AE_THRESH);
  localparam logic [COUNT_W-1:0] ONE_COUNT  = COUNT_W'(1);
  localparam logic [BUDGET_W-1:0] ONE_WORD  = BUDGET_W'(1);
  // Per-channel storage state
  logic [NUM_CHAN-1:0][COUNT_W-1:0] count;
  logic [NUM_CHAN-1:0][COUNT_W-1:0] next_count;
  logic [NUM_CHAN-1:0][COUNT_W-1:0] eop_cnt;
  logic [NUM_CHAN-1:0][COUNT_W-1:0] next_eop_cnt;
  logic [NUM_CHAN-1:0][ADDR_W-1:0]  wr_ptr;
  logic [NUM_CHAN-1:0][ADDR_W-1:0]  rd_ptr;
  logic [NUM_CHAN-1:0][ADDR_W-1:0]  rd_addr;
  qsb_entry_type [NUM_CHAN-1:0]     head;
  qsb_entry_type [NUM_CHAN-1:0]     entry_wr;
  qsb_rx_word_type [NUM_CHAN-1:0]   half_word;
  logic [NUM_CHAN-1:0]              half_valid;
  logic [NUM_CHAN-1:0]              take;
  logic [NUM_CHAN-1:0]              write_en;
  logic [NUM_CHAN-1:0]              pop;
  logic [NUM_CHAN-1:0]              full;
  logic [NUM_CHAN-1:0]              eligible;
  logic [NUM_CHAN-1:0]              want;
  // Arbiter state
  qsb_arb_state_type   state;
  logic [CHAN_W-1:0]   sel;
  logic [CHAN_W-1:0]   last;
  logic [CHAN_W-1:0]   pick;
  logic                found;
  logic [BUDGET_W-1:0] budget;
  logic                hungry_mode;
  logic                storage_read_strobe;
  logic                storage_read_valid;
  logic                storage_next_word_end;
  logic                last_word;
  ////////////////////////////////////////////////////////////////////////////
  // Receive side, packing and burst storage, one slice per channel
  for (genvar g = 0; g < NUM_CHAN; g++)
  begin : g_chan
    logic [2:0] mod_end;
    // Word moves only with ready and room
    assign take[g] = receive_side_ready_i[g] & rx_read_enable_o[g]
                   & ~full[g];
    assign full[g] = (count[g] == FULL_COUNT);
    // Bytes in the final entry, modulo eight: first half 1-4, second 5-8
    assign mod_end = {half_valid[g], rx_word_i[g].remainder_bytes}
                   + MOD_STEP;
    // An entry is written on the second word or on an early end
    assign write_en[g] = take[g] & (half_valid[g] | rx_word_i[g].eop);
    assign entry_wr[g].eop    = {3{rx_word_i[g].eop}};
    assign entry_wr[g].sop    = half_valid[g] ? half_word[g].sop
                                              : rx_word_i[g].sop;
    assign entry_wr[g].err    = rx_word_i[g].err
                              | (half_valid[g] & half_word[g].err);
    assign entry_wr[g].modulo = rx_word_i[g].eop ? mod_end : MOD_NONE;
    assign entry_wr[g].first  = half_valid[g] ? half_word[g].data
                                              : rx_word_i[g].data;
    assign entry_wr[g].second = half_valid[g] ? rx_word_i[g].data : WORD_ZERO;
    assign pop[g]     = storage_read_strobe & (sel == CHAN_W'(g));
    assign rd_addr[g] = rd_ptr[g] + ADDR_W'(pop[g]);
    assign next_count[g] = count[g] + COUNT_W'(write_en[g])
                         - COUNT_W'(pop[g]);
    assign next_eop_cnt[g] = eop_cnt[g]
                           + COUNT_W'(write_en[g] & rx_word_i[g].eop)
                           - COUNT_W'(pop[g] & head[g].eop[0]);
    // Eligible with a complete packet stored or plenty of data
    assign eligible[g] = (eop_cnt[g] != '0)
                       | (count[g] > AE_COUNT);
    assign want[g] = eligible[g] & ((channel_status_i[g] == STATUS_STARVING)
                   | (channel_status_i[g] == STATUS_HUNGRY));
    // Half-entry holding register
    always_ff @(posedge clk_i)
    begin
      if (reset_i)
        half_valid[g] <= 1'b0;
      else if (take[g])
        half_valid[g] <= ~half_valid[g] & ~rx_word_i[g].eop;
      if (take[g] && !half_valid[g])
        half_word[g] <= rx_word_i[g];
    end
    // Pointers, occupancy and end-marker count
    always_ff @(posedge clk_i)
    begin
      if (reset_i)
      begin
        wr_ptr[g]  <= '0;
        rd_ptr[g]  <= '0;
        count[g]   <= '0;
        eop_cnt[g] <= '0;
      end
      else
      begin
        wr_ptr[g]  <= wr_ptr[g] + ADDR_W'(write_en[g]);
        rd_ptr[g]  <= rd_addr[g];
        count[g]   <= next_count[g];
        eop_cnt[g] <= next_eop_cnt[g];
      end
    end
    // Registered status from next values; enable falls as the last entry lands
    always_ff @(posedge clk_i)
    begin
      if (reset_i)
      begin
        rx_read_enable_o[g]       <= 1'b0;
        storage_full_o[g]         <= 1'b0;
        storage_almost_empty_o[g] <= 1'b1;
        single_packet_flag_o[g]   <= 1'b0;
        packet_present_flag_o[g]  <= 1'b0;
      end
      else
      begin
        rx_read_enable_o[g]       <= next_count[g] < FULL_COUNT;
        storage_full_o[g]         <= next_count[g] == FULL_COUNT;
        storage_almost_empty_o[g] <= next_count[g] <= AE_COUNT;
        single_packet_flag_o[g]   <= next_eop_cnt[g] == ONE_COUNT;
        packet_present_flag_o[g]  <= (next_eop_cnt[g] != '0)
                                   | (write_en[g] & rx_word_i[g].eop);
      end
    end
    // One 512-entry store per receive core
    qsb_mem #(.WIDTH (ENTRY_W), .DEPTH (ENTRY_DEPTH), .ADDR_W (ADDR_W))
    u_store (
      .clk_i        (clk_i),
      .write_i      (write_en[g]),
      .write_addr_i (wr_ptr[g]),
      .write_data_i (entry_wr[g]),
      .read_addr_i  (rd_addr[g]),
      .read_data_o  (head[g])
    );
    property p_write_grows;
      (write_en[g] && !pop[g]) |=> (count[g] == $past(count[g]) + ONE_COUNT);
    endproperty
    a_write_grows: assert property (p_write_grows)
      else $error("store count did not grow on write");
    property p_pair_writes;
      (take[g] && half_valid[g]) |-> write_en[g] ##1 !half_valid[g];
    endproperty
    a_pair_writes: assert property (p_pair_writes)
      else $error("second word did not complete an entry");
    property p_single;
      single_packet_flag_o[g] |-> (eop_cnt[g] == ONE_COUNT);
    endproperty
    a_single: assert property (p_single)
      else $error("single packet flag wrong");
    property p_present;
      (eop_cnt[g] != '0) |-> packet_present_flag_o[g];
    endproperty
    a_present: assert property (p_present)
      else $error("packet present flag missing");
  end : g_chan
  ////////////////////////////////////////////////////////////////////////////
  // Arbiter: round-robin search starting after the last channel served
  always_comb
  begin
    logic [CHAN_W-1:0] idx;
    idx   = last;
    found = 1'b0;
    pick  = last;
    for (int i = 1; i <= NUM_CHAN; i++)
    begin
      idx = last + CHAN_W'(i);
      if (!found && want[idx])
      begin
        found = 1'b1;
        pick  = idx;
      end
    end
  end
  // Storage read handshake for the selected channel
  assign storage_read_valid    = (count[sel] != '0);
  assign storage_next_word_end = head[sel].eop[0];
  assign storage_read_strobe   = (state == ARB_BURST) & storage_read_valid
                               & (budget != '0) & ~source_fifo_full_i;
  // Burst ends on budget, on a hungry end word, or when the store runs dry
  assign last_word = (storage_read_strobe & ((budget == ONE_WORD)
                   | (hungry_mode & storage_next_word_end)))
                   | ((state == ARB_BURST) & ~storage_read_valid);
  // Grant and burst bookkeeping
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state       <= ARB_IDLE;
      sel         <= '0;
      last        <= '0;
      budget      <= '0;
      hungry_mode <= 1'b0;
    end
    else
    begin
      unique case (state)
        ARB_IDLE:
        begin
          if (found)
          begin
            state       <= ARB_BURST;
            sel         <= pick;
            last        <= pick;
            hungry_mode <= channel_status_i[pick] == STATUS_HUNGRY;
            // Whole credits only, two entries each
            budget      <= (channel_status_i[pick] == STATUS_STARVING)
                         ? STARVE_WORDS : HUNGRY_WORDS;
          end
        end
        ARB_BURST:
        begin
          budget <= budget - BUDGET_W'(storage_read_strobe);
          if (last_word)
            state <= ARB_IDLE;
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Source FIFO write port, registered from the popped head word
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      source_fifo_write_o       <= 1'b0;
      source_fifo_channel_o     <= '0;
      source_fifo_data_o        <= '0;
      source_fifo_start_flag_o  <= 1'b0;
      source_fifo_end_flag_o    <= 1'b0;
      source_fifo_error_flag_o  <= 1'b0;
      source_fifo_byte_modulo_o <= MOD_NONE;
    end
    else
    begin
      source_fifo_write_o      <= storage_read_strobe;
      source_fifo_channel_o    <= sel;
      source_fifo_data_o       <= {head[sel].first, head[sel].second};
      source_fifo_start_flag_o <= storage_read_strobe & head[sel].sop;
      source_fifo_end_flag_o   <= storage_read_strobe
                                & head[sel].eop[0];
      source_fifo_error_flag_o <= storage_read_strobe & head[sel].err;
      // The modulo steers the source core's end code; keep it clean
      source_fifo_byte_modulo_o <= (storage_read_strobe & head[sel].eop[0])
                                 ? head[sel].modulo : MOD_NONE;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Checks on the arbiter and source port
  sequence s_grant;
    (state == ARB_IDLE) && found;
  endsequence
  property p_mod_zero;
    !source_fifo_end_flag_o |-> (source_fifo_byte_modulo_o == MOD_NONE);
  endproperty
  a_mod_zero: assert property (p_mod_zero)
    else $error("modulo not zero without end flag");
  property p_grant_eligible;
    s_grant |-> eligible[pick];
  endproperty
  a_grant_eligible: assert property (p_grant_eligible)
    else $error("ineligible channel granted");
  property p_starve_budget;
    (s_grant and (channel_status_i[pick] == STATUS_STARVING))
      |=> (budget == STARVE_WORDS) && (state == ARB_BURST);
  endproperty
  a_starve_budget: assert property (p_starve_budget)
    else $error("starving burst size wrong");
  property p_hungry_stop;
    (storage_read_strobe && hungry_mode && storage_next_word_end)
      |=> (state == ARB_IDLE) ##1 !source_fifo_write_o;
  endproperty
  a_hungry_stop: assert property (p_hungry_stop)
    else $error("hungry burst ran past end word");
  property p_source_follows;
    storage_read_strobe |=> source_fifo_write_o
      && (source_fifo_channel_o == $past(sel));
  endproperty
  a_source_follows: assert property (p_source_follows)
    else $error("read strobe not followed by source write");
endmodule : qsb_bridge
`default_nettype wire

/* qsb_rx_model.sv */
`timescale 1ns/1ns
`default_nettype none
module qsb_rx_model
(
  // Clock and reset
  input  wire logic                              clk_i,
  input  wire logic                              reset_i,
  // Bridge side
  input  wire logic [qsb_pkg::NUM_CHAN-1:0]      rx_read_enable_i,
  output var  qsb_pkg::qsb_rx_word_type [3:0]    rx_word_o,
  output var  logic [qsb_pkg::NUM_CHAN-1:0]      receive_side_ready_o
);
  import qsb_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Words queued by the bench, one queue per receive core
  qsb_rx_word_type pend [NUM_CHAN][$];
  bit              slow;
  bit              phase;
  int              taken [NUM_CHAN];

  initial
  begin
    rx_word_o = '0;
    receive_side_ready_o = '0;
  end

  // A word stays offered until taken; slow mode offers every other cycle.
  // Idle lines invert their value every cycle so stale data never helps.
  always @(posedge clk_i)
  begin
    phase <= ~phase;
    for (int c = 0; c < NUM_CHAN; c++)
    begin
      if (!reset_i && receive_side_ready_o[c] && rx_read_enable_i[c])
      begin
        pend[c].delete(0);
        taken[c]++;
      end
      if (!reset_i && pend[c].size() > 0 && !(slow && phase))
      begin
        receive_side_ready_o[c] <= 1'h1;
        rx_word_o[c]            <= pend[c][0];
      end
      else
      begin
        receive_side_ready_o[c] <= 1'h0;
        rx_word_o[c]            <= ~rx_word_o[c];
      end
    end
  end
endmodule : qsb_rx_model
`default_nettype wire

/* qsb_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
  import qsb_pkg::*;
  // Short bursts and threshold keep the run brief
  localparam int SB = 2;
  localparam int HB = 1;
  localparam int AE = 5;

  logic                     clk_i = 1'h0;
  logic                     reset_i = 1'h1;
  logic [NUM_CHAN-1:0][1:0] status = '1;
  qsb_rx_word_type [3:0]    rx_word;
  logic [3:0]               ready;
  logic [3:0]               rd_en;
  logic                     wr;
  logic [1:0]               ch;
  logic [63:0]              data;
  logic                     sof;
  logic                     eof;
  logic                     erf;
  logic [2:0]               md;
  logic [3:0]               full_o;
  logic [3:0]               ae;
  logic [3:0]               single;
  logic [3:0]               present;
  logic [71:0]              exp_q [NUM_CHAN][$];
  logic [71:0]              got_q [$];
  int                       wtime [$];
  int                       cyc;
  int                       seq;
  int                       n_mismatch;
  int                       samples_checked;

  always #50 clk_i = ~clk_i;

  qsb_rx_model far
  (
    .clk_i                (clk_i),
    .reset_i              (reset_i),
    .rx_read_enable_i     (rd_en),
    .rx_word_o            (rx_word),
    .receive_side_ready_o (ready)
  );

  qsb_bridge
  #(
    .STARVE_BURST (SB),
    .HUNGRY_BURST (HB),
    .AE_THRESH    (AE)
  )
  dut
  (
    .clk_i                     (clk_i),
    .reset_i                   (reset_i),
    .rx_word_i                 (rx_word),
    .receive_side_ready_i      (ready),
    .rx_read_enable_o          (rd_en),
    .channel_status_i          (status),
    .source_fifo_full_i        (1'h0),
    .source_fifo_write_o       (wr),
    .source_fifo_channel_o     (ch),
    .source_fifo_data_o        (data),
    .source_fifo_start_flag_o  (sof),
    .source_fifo_end_flag_o    (eof),
    .source_fifo_error_flag_o  (erf),
    .source_fifo_byte_modulo_o (md),
    .storage_full_o            (full_o),
    .storage_almost_empty_o    (ae),
    .single_packet_flag_o      (single),
    .packet_present_flag_o     (present)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Capture every source write with the cycle it landed in
  always @(posedge clk_i)
  begin
    cyc++;
    if (wr === 1'h1)
    begin
      got_q.push_back({ch, eof, sof, erf, md, data});
      wtime.push_back(cyc);
    end
  end

  // Hang guard, well beyond the few thousand cycles the tests need
  initial
  begin
    #3000000;
    n_mismatch++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  task automatic check(input logic [71:0] g, input logic [71:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check

  // Inputs move 1 ns after the edge so sampling never races
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step

  task automatic clr;
    got_q.delete();
    wtime.delete();
  endtask : clr

  // Queue words and work out the packed entries they must become
  task automatic send(input int c, input int n, input bit s, input bit e,
                      input logic [1:0] r, input bit er);
    qsb_rx_word_type w;
    qsb_rx_word_type f;
    for (int i = 0; i < n; i++)
    begin
      w.data = {c[7:0], 24'(seq)};
      seq++;
      w.sop = s && (i == 0);
      w.eop = e && (i == n - 1);
      w.err = er && w.eop;
      w.remainder_bytes = w.eop ? r : 2'h0;
      far.pend[c].push_back(w);
      if (i % 2 == 0 && w.eop)
        exp_q[c].push_back({c[1:0], 1'h1, w.sop, w.err,
          3'({1'h0, r} + 3'h1), w.data, 32'h0});
      else if (i % 2 == 0)
        f = w;
      else
        exp_q[c].push_back({c[1:0], w.eop, f.sop, f.err | w.err,
          w.eop ? 3'({1'h0, r} + 3'h5) : 3'h0, f.data, w.data});
    end
  endtask : send

  // Wait for every expected entry, then match them per channel
  task automatic drain;
    int k;
    int tot;
    k = 0;
    tot = 0;
    for (int c = 0; c < NUM_CHAN; c++)
      tot += exp_q[c].size();
    while (got_q.size() < tot && k < 6000)
    begin
      step(1);
      k++;
    end
    step(6);
    check(72'(got_q.size()), 72'(tot));
    foreach (got_q[i])
      check(got_q[i], exp_q[got_q[i][71:70]].pop_front());
  endtask : drain

  ////////////////////////////////////////////////////////////////////////////
  // Lengths 1 to 4 with every remainder, those with remainder 2 ending with an error
  task automatic t_mod;
    clr();
    for (int n = 1; n <= 4; n++)
      for (int r = 0; r < 4; r++)
        send(0, n, 1, 1, r[1:0], r == 2);
    status[0] = STATUS_STARVING;
    drain();
    status[0] = 2'h3;
  endtask : t_mod

  task automatic t_flags;
    clr();
    send(2, 2, 1, 1, 2'h3, 0);
    step(6);
    check(72'({single[2], present[2], ae[2]}), 72'h7);
    send(2, 2, 1, 1, 2'h3, 0);
    step(6);
    check(72'({single[2], present[2], ae[2]}), 72'h3);
    status[2] = STATUS_STARVING;
    drain();
    status[2] = 2'h3;
  endtask : t_flags

  // Open packet: ineligible at the threshold, one burst just above it
  task automatic t_elig;
    clr();
    status[3] = STATUS_STARVING;
    send(3, 10, 1, 0, 2'h0, 0);
    step(30);
    check(72'(got_q.size()), 72'h0);
    check(72'(ae[3]), 72'h1);
    send(3, 2, 0, 0, 2'h0, 0);
    step(40);
    check(72'(got_q.size()), 72'(2 * SB));
    send(3, 2, 0, 1, 2'h1, 0);
    drain();
    status[3] = 2'h3;
  endtask : t_elig

  // Burst lengths measured from runs of back-to-back writes
  task automatic t_runs(input logic [1:0] s, input int np, input int nw);
    int b;
    int left;
    int run;
    int idx;
    int got;
    clr();
    for (int p = 0; p < np; p++)
      send(1, nw, 1, 1, 2'h3, 0);
    status[1] = s;
    drain();
    status[1] = 2'h3;
    b = (s == STATUS_HUNGRY) ? 2 * HB : 2 * SB;
    idx = 0;
    for (int p = 0; p < ((s == STATUS_HUNGRY) ? np : 1); p++)
    begin
      left = (s == STATUS_HUNGRY) ? nw / 2 : np * nw / 2;
      while (left > 0)
      begin
        run = (left < b) ? left : b;
        got = (idx < wtime.size()) ? 1 : 0;
        while (idx + got < wtime.size() && wtime[idx + got] == wtime[idx] + got)
          got++;
        idx += got;
        check(72'(got), 72'(run));
        left -= run;
      end
    end
  endtask : t_runs

  task automatic t_rr;
    clr();
    far.slow = 1'h1;
    for (int c = 0; c < NUM_CHAN; c++)
      send(c, 2, 1, 1, 2'h0, 0);
    step(20);
    status = '0;
    drain();
    status = '1;
    far.slow = 1'h0;
    for (int i = 1; i < NUM_CHAN; i++)
      check(72'(got_q[i][71:70]), 72'(2'(got_q[i-1][71:70] + 2'h1)));
  endtask : t_rr

  // Fill one store until it refuses, then drain with nothing lost
  task automatic t_fill;
    int t0;
    clr();
    t0 = far.taken[3];
    for (int i = 0; i < 11; i++)
      send(3, 100, i == 0, 0, 2'h0, 0);
    step(1200);
    check(72'({full_o[3], rd_en[3], ae[3]}), 72'h4);
    check(72'((far.taken[3] - t0) inside {[1016:1024]}), 72'h1);
    send(3, 2, 0, 1, 2'h0, 0);
    status[3] = STATUS_STARVING;
    drain();
    status[3] = 2'h3;
  endtask : t_fill

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    step(4);
    check(72'({full_o, ae, single, present, wr}), 72'h1e00);
    reset_i = 1'h0;
    step(2);
    t_mod();
    t_flags();
    t_elig();
    t_runs(STATUS_STARVING, 1, 20);
    t_runs(STATUS_HUNGRY, 1, 20);
    t_runs(STATUS_HUNGRY, 2, 2);
    t_runs(STATUS_STARVING, 2, 2);
    t_rr();
    t_fill();
    end_sim();
  end
endmodule : tb
`default_nettype wire
